// ===== core/mir_pkg.sv
// constants of the motion and image readout register block
`default_nettype none

package mir_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] ADDR_PRODUCT_IDENTIFIER = 7'h00;
    localparam logic [6:0] ADDR_SILICON_REVISION = 7'h01;
    localparam logic [6:0] ADDR_MOVEMENT_FLAG = 7'h02;
    localparam logic [6:0] ADDR_X_DISPLACEMENT = 7'h03;
    localparam logic [6:0] ADDR_Y_DISPLACEMENT = 7'h04;
    localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
    localparam logic [6:0] ADDR_EXPOSURE_TIME_HIGH = 7'h06;
    localparam logic [6:0] ADDR_EXPOSURE_TIME_LOW = 7'h07;
    localparam logic [6:0] ADDR_BRIGHTEST_PIXEL = 7'h08;
    localparam logic [6:0] ADDR_MEAN_PIXEL_LEVEL = 7'h09;
    localparam logic [6:0] ADDR_DARKEST_PIXEL = 7'h0a;
    localparam logic [6:0] ADDR_PIXEL_DUMP_PORT = 7'h0b;
    localparam logic [6:0] ADDR_TRACKING_CONTROL_COMMIT = 7'h21;
    localparam logic [6:0] ADDR_SOFT_RESET_TRIGGER = 7'h3a;
    localparam logic [6:0] ADDR_INVERTED_REVISION = 7'h3f;
    localparam logic [6:0] ADDR_MOVEMENT_BURST_PORT = 7'h63;

    // ****************************************
    // stored configuration registers
    // ****************************************
    localparam int CFG_NUM = 13;
    localparam logic [CFG_NUM-1:0][6:0] CFG_ADDR = {
        7'h45, 7'h43, 7'h42, 7'h41, 7'h40, 7'h35, 7'h13,
        7'h12, 7'h11, 7'h10, 7'h0f, 7'h0e, 7'h0d};
    localparam logic [CFG_NUM-1:0][7:0] CFG_RST = {
        8'h00, 8'h08, 8'h03, 8'h40, 8'h00, 8'hf0, 8'h31,
        8'h2f, 8'h09, 8'h4f, 8'h00, 8'h46, 8'h01};
    localparam logic [3:0] CFG_IDX_NONE = 4'hf;
    localparam logic [3:0] CFG_IDX_BURST_START = 4'ha;

    // ****************************************
    // identity, arbitrary values
    // ****************************************
    localparam logic [7:0] PRODUCT_ID_VALUE = 8'h5c;
    localparam logic [7:0] REVISION_VALUE = 8'h03;

    // ****************************************
    // fields, reset values, limits
    // ****************************************
    localparam int MOVEMENT_FLAG_BIT = 7;
    localparam int PIXEL_DUMP_VALID_BIT = 7;
    localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;
    localparam logic [15:0] EXPOSURE_RST = 16'h0100;
    localparam logic [15:0] EXPOSURE_MIN = 16'h0001;
    localparam logic [15:0] EXPOSURE_MAX = 16'hffff;
    localparam logic [7:0] BRIGHT_HIGH_LIMIT = 8'hf0;
    localparam logic [7:0] MEAN_HIGH_LIMIT = 8'hb0;
    localparam logic [7:0] BRIGHT_LOW_LIMIT = 8'h80;
    localparam logic [7:0] MEAN_LOW_LIMIT = 8'h40;
    localparam logic [7:0] DARKEST_LIMIT = 8'h7f;
    localparam logic [8:0] PIXEL_COUNT = 9'h0169;

    // ****************************************
    // serial port phases
    // ****************************************
    typedef enum logic [1:0] {
        MIR_PH_ADDR = 2'b00,
        MIR_PH_WDATA = 2'b01,
        MIR_PH_RDATA = 2'b10
    } mir_phase_t;

endpackage

`default_nettype wire

// ===== core/mir_readout_regs.sv
// register set, serial slave and frame statistics of the motion sensor
// Functional notes
// R01: every register reachable over four-wire serial port with byte addresses
// R02: movement flag set when motion seen since Y displacement last read or status written
// R03: movement flag at status bit 7; bits 6-0 read zero
// R04: any status write clears flag and both displacements; byte not kept
// R05: controller reads status first, then displacements 0x03 and 0x04
// R06: displacements accumulate as saturating 8-bit two's complement
// R07: controller reads X then Y back to back
// R08: surface quality reports valid features of current frame
// R09: surface quality is upper 8 bits of 9-bit count
// R10: exposure is 16-bit cycle count in high and low byte
// R11: controller reads exposure high byte then low byte at once
// R12: exposure adjusted automatically to keep pixel levels in range
// R13: brightest pixel register holds frame maximum 0 to 255
// R14: darkest pixel register holds frame minimum 0 to 127
// R15: any pixel dump write returns grabber to position 0
// R16: controller needs 361 dump reads with sensor held still
// R17: product identifier holds fixed 8-bit code
// R18: after all motion data read, displacements and flag clear
// R19: burst read returns X, Y, quality, exposure, brightest, mean
// R20: dump port: valid bit 7, pixel bits 6:0, read advances
// R21: writes to read-only registers ignored except status clear and pixel dump grabber restart
// R22: reset loads every register with its default
`timescale 1ns/1ps
`default_nettype none

module mir_readout_regs (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // serial port
    input wire logic ncs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // frame results from image processor
    input wire logic frame_done_i,
    input wire logic motion_valid_i,
    input wire logic [7:0] motion_dx_i,
    input wire logic [7:0] motion_dy_i,
    input wire logic [8:0] feature_count_i,
    input wire logic [7:0] frame_max_i,
    input wire logic [7:0] frame_mean_i,
    input wire logic [7:0] frame_min_i,
    // pixel array write port
    input wire logic pix_we_i,
    input wire logic [8:0] pix_addr_i,
    input wire logic [6:0] pix_data_i,
    // to image processor
    output logic [15:0] exposure_o,
    output logic motion_pending_o
);
    import mir_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic ncs_s1;
        logic ncs_s2;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic mosi_s1;
        logic mosi_s2;
        mir_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic [6:0] addr;
        logic [7:0] out_sh;
        logic burst;
        logic [6:0] burst_addr;
        logic miso;
        logic miso_oe;
        logic flag;
        logic [7:0] dx;
        logic [7:0] dy;
        logic [7:0] squal;
        logic [15:0] exposure;
        logic [7:0] pmax;
        logic [7:0] pmean;
        logic [7:0] pmin;
        logic [8:0] grab_pos;
        logic frame_seen;
        logic [CFG_NUM-1:0][7:0] cfg;
    } mir_state_t;

    mir_state_t st_reg;
    mir_state_t st_next;
    logic [6:0] pix_mem [0:360];
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] shifted;
    logic rd_stb;
    logic [6:0] rd_addr;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;
    logic grab_valid;

    // ****************************************
    // functions
    // ****************************************
    function automatic mir_state_t rst_state();
        mir_state_t s;
        s = '0;
        s.ncs_s1 = 1'b1;
        s.ncs_s2 = 1'b1;
        s.exposure = EXPOSURE_RST;
        s.cfg = CFG_RST;
        return s;
    endfunction

    function automatic logic [3:0] cfg_index(input logic [6:0] a);
        logic [3:0] idx;
        idx = CFG_IDX_NONE;
        for (int i = 0; i < CFG_NUM; i++) begin
            if (CFG_ADDR[i] == a) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {a[7], a} + {b[7], b};
        if (s[8] != s[7]) begin
            sat_add = s[8] ? 8'h80 : 8'h7f;
        end else begin
            sat_add = s[7:0];
        end
    endfunction

    function automatic logic [6:0] burst_next(input logic [6:0] a);
        if (a < ADDR_MEAN_PIXEL_LEVEL) begin
            burst_next = 7'(a + 7'h01);
        end else begin
            burst_next = ADDR_MEAN_PIXEL_LEVEL;
        end
    endfunction

    // ****************************************
    // serial decode
    // ****************************************
    always_comb begin
        sclk_rise = st_reg.sclk_s2 & ~st_reg.sclk_s3;
        sclk_fall = ~st_reg.sclk_s2 & st_reg.sclk_s3;
        shifted = {st_reg.shift_in[6:0], st_reg.mosi_s2};
        rd_stb = 1'b0;
        rd_addr = '0;
        wr_stb = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        if (!st_reg.ncs_s2 && sclk_rise && st_reg.bit_cnt == 3'h7) begin
            case (st_reg.phase)
                MIR_PH_ADDR: begin
                    if (!shifted[7]) begin
                        rd_stb = 1'b1;
                        if (shifted[6:0] == ADDR_MOVEMENT_BURST_PORT) begin
                            rd_addr = st_reg.cfg[CFG_IDX_BURST_START][6:0]; // R19
                        end else begin
                            rd_addr = shifted[6:0]; // R01
                        end
                    end
                end
                MIR_PH_WDATA: begin
                    wr_stb = 1'b1;
                    wr_addr = st_reg.addr;
                    wr_data = shifted;
                end
                MIR_PH_RDATA: begin
                    rd_stb = st_reg.burst;
                    rd_addr = st_reg.burst_addr; // R19
                end
                default: begin
                    rd_stb = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rd_idx = cfg_index(rd_addr);
        wr_idx = cfg_index(wr_addr);
        grab_valid = st_reg.frame_seen && st_reg.grab_pos < PIXEL_COUNT;
        rd_byte = 8'h00;
        case (rd_addr)
            ADDR_PRODUCT_IDENTIFIER: rd_byte = PRODUCT_ID_VALUE; // R17
            ADDR_SILICON_REVISION: rd_byte = REVISION_VALUE;
            ADDR_MOVEMENT_FLAG: rd_byte = {st_reg.flag, 7'h00}; // R03
            ADDR_X_DISPLACEMENT: rd_byte = st_reg.dx;
            ADDR_Y_DISPLACEMENT: rd_byte = st_reg.dy;
            ADDR_SURFACE_QUALITY: rd_byte = st_reg.squal;
            ADDR_EXPOSURE_TIME_HIGH: rd_byte = st_reg.exposure[15:8]; // R10
            ADDR_EXPOSURE_TIME_LOW: rd_byte = st_reg.exposure[7:0]; // R10
            ADDR_BRIGHTEST_PIXEL: rd_byte = st_reg.pmax;
            ADDR_MEAN_PIXEL_LEVEL: rd_byte = st_reg.pmean;
            ADDR_DARKEST_PIXEL: rd_byte = st_reg.pmin;
            ADDR_PIXEL_DUMP_PORT: begin
                if (grab_valid) begin
                    rd_byte = {1'b1, pix_mem[st_reg.grab_pos]}; // R20
                end
            end
            ADDR_INVERTED_REVISION: rd_byte = ~REVISION_VALUE;
            default: begin
                if (rd_idx != CFG_IDX_NONE) begin
                    rd_byte = st_reg.cfg[rd_idx];
                end
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.ncs_s1 = ncs_n_i;
        st_next.ncs_s2 = st_reg.ncs_s1;
        st_next.sclk_s1 = sclk_i;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_s3 = st_reg.sclk_s2;
        st_next.mosi_s1 = mosi_i;
        st_next.mosi_s2 = st_reg.mosi_s1;
        st_next.miso_oe = ~st_reg.ncs_s2; // R01
        if (st_reg.ncs_s2) begin
            st_next.phase = MIR_PH_ADDR;
            st_next.bit_cnt = 3'h0;
            st_next.burst = 1'b0;
        end else if (sclk_rise) begin
            st_next.shift_in = shifted;
            st_next.bit_cnt = 3'(st_reg.bit_cnt + 3'h1);
            if (st_reg.bit_cnt == 3'h7) begin
                case (st_reg.phase)
                    MIR_PH_ADDR: begin
                        st_next.addr = shifted[6:0];
                        st_next.phase = shifted[7] ? MIR_PH_WDATA : MIR_PH_RDATA;
                        st_next.burst = shifted[6:0] == ADDR_MOVEMENT_BURST_PORT;
                    end
                    MIR_PH_RDATA: begin
                        if (!st_reg.burst) begin
                            st_next.phase = MIR_PH_ADDR;
                        end
                    end
                    default: begin
                        st_next.phase = MIR_PH_ADDR;
                    end
                endcase
            end
        end else if (sclk_fall && st_reg.phase == MIR_PH_RDATA) begin
            st_next.miso = st_reg.out_sh[7];
            st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
        end
        if (rd_stb) begin
            st_next.out_sh = rd_byte;
            st_next.burst_addr = burst_next(rd_addr);
            if (rd_addr == ADDR_Y_DISPLACEMENT) begin
                st_next.flag = 1'b0; // R18
                st_next.dx = 8'h00;
                st_next.dy = 8'h00;
            end
            if (rd_addr == ADDR_PIXEL_DUMP_PORT && st_reg.grab_pos < PIXEL_COUNT) begin
                st_next.grab_pos = 9'(st_reg.grab_pos + 9'h001); // R20
            end
        end
        if (wr_stb) begin
            if (wr_addr == ADDR_MOVEMENT_FLAG) begin
                st_next.flag = 1'b0; // R04
                st_next.dx = 8'h00;
                st_next.dy = 8'h00;
            end
            if (wr_addr == ADDR_PIXEL_DUMP_PORT) begin
                st_next.grab_pos = 9'h000; // R15
            end
            if (wr_idx != CFG_IDX_NONE) begin
                st_next.cfg[wr_idx] = wr_data; // R21
            end
        end
        if (frame_done_i) begin
            if (motion_valid_i) begin
                st_next.flag = 1'b1; // R02
                st_next.dx = sat_add(st_next.dx, motion_dx_i); // R06
                st_next.dy = sat_add(st_next.dy, motion_dy_i); // R06
            end
            st_next.squal = feature_count_i[8:1]; // R08 R09
            st_next.pmax = frame_max_i; // R13
            st_next.pmean = frame_mean_i;
            st_next.pmin = frame_min_i > DARKEST_LIMIT ? DARKEST_LIMIT : frame_min_i; // R14
            st_next.frame_seen = 1'b1;
            if (frame_max_i >= BRIGHT_HIGH_LIMIT || frame_mean_i >= MEAN_HIGH_LIMIT) begin
                if (st_reg.exposure > EXPOSURE_MIN + (st_reg.exposure >> 4)) begin
                    st_next.exposure = st_reg.exposure - (st_reg.exposure >> 4) - 16'h0001; // R12
                end else begin
                    st_next.exposure = EXPOSURE_MIN; // R12
                end
            end else if (frame_max_i < BRIGHT_LOW_LIMIT && frame_mean_i < MEAN_LOW_LIMIT) begin
                if (st_reg.exposure < EXPOSURE_MAX - (st_reg.exposure >> 4) - 16'h0001) begin
                    st_next.exposure = st_reg.exposure + (st_reg.exposure >> 4) + 16'h0001; // R12
                end else begin
                    st_next.exposure = EXPOSURE_MAX; // R12
                end
            end
        end
        if (wr_stb && wr_addr == ADDR_SOFT_RESET_TRIGGER && wr_data == SOFT_RESET_KEY) begin
            st_next = rst_state(); // R22
            // pin synchronisers keep tracking, no false link edge, miso stays driven
            st_next.ncs_s1 = ncs_n_i;
            st_next.ncs_s2 = st_reg.ncs_s1;
            st_next.sclk_s1 = sclk_i;
            st_next.sclk_s2 = st_reg.sclk_s1;
            st_next.sclk_s3 = st_reg.sclk_s2;
            st_next.mosi_s1 = mosi_i;
            st_next.mosi_s2 = st_reg.mosi_s1;
            st_next.miso_oe = ~st_reg.ncs_s2;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_reg <= rst_state(); // R22
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (pix_we_i && pix_addr_i < PIXEL_COUNT) begin
            pix_mem[pix_addr_i] <= pix_data_i;
        end
    end

    assign miso_o = st_reg.miso;
    assign miso_oe_o = st_reg.miso_oe;
    assign exposure_o = st_reg.exposure;
    assign motion_pending_o = st_reg.flag;

    // ****************************************
    // assertions
    // ****************************************
    property p_flag_set;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (frame_done_i && motion_valid_i && !wr_stb) |=> st_reg.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R02

    property p_status_clear;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wr_stb && wr_addr == ADDR_MOVEMENT_FLAG && !frame_done_i)
            |=> (!st_reg.flag && st_reg.dx == 8'h00 && st_reg.dy == 8'h00);
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status write"); // R04

    property p_status_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (rd_stb && rd_addr == ADDR_MOVEMENT_FLAG)
            |=> st_reg.out_sh == {$past(st_reg.flag), 7'h00};
    endproperty
    a_status_byte: assert property (p_status_byte) else $error("status byte"); // R03

    property p_y_read_clear;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (rd_stb && rd_addr == ADDR_Y_DISPLACEMENT && !frame_done_i) |=> !st_reg.flag;
    endproperty
    a_y_read_clear: assert property (p_y_read_clear) else $error("y read"); // R18

    property p_grab_origin;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wr_stb && wr_addr == ADDR_PIXEL_DUMP_PORT) |=> st_reg.grab_pos == 9'h000;
    endproperty
    a_grab_origin: assert property (p_grab_origin) else $error("grab origin"); // R15

    property p_grab_step;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (rd_stb && rd_addr == ADDR_PIXEL_DUMP_PORT && st_reg.grab_pos < 9'h0168)
            |=> st_reg.grab_pos == 9'($past(st_reg.grab_pos) + 9'h001);
    endproperty
    a_grab_step: assert property (p_grab_step) else $error("grab step"); // R20

    property p_squal;
        @(posedge mclk_i) disable iff (!rst_n_i)
        frame_done_i |=> st_reg.squal == 8'($past(feature_count_i) >> 1);
    endproperty
    a_squal: assert property (p_squal) else $error("quality value"); // R09

    property p_darkest;
        @(posedge mclk_i) disable iff (!rst_n_i)
        frame_done_i |=> st_reg.pmin <= DARKEST_LIMIT;
    endproperty
    a_darkest: assert property (p_darkest) else $error("darkest range"); // R14

    property p_exposure_down;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (frame_done_i && frame_max_i >= BRIGHT_HIGH_LIMIT && !wr_stb)
            |=> (st_reg.exposure < $past(st_reg.exposure) || st_reg.exposure == EXPOSURE_MIN);
    endproperty
    a_exposure_down: assert property (p_exposure_down) else $error("exposure"); // R12

    property p_drive;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !st_reg.ncs_s2 |=> miso_oe_o;
    endproperty
    a_drive: assert property (p_drive) else $error("miso not driven"); // R01

    c_burst: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_stb && st_reg.burst && st_reg.phase == MIR_PH_RDATA);
    c_clear: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_stb && wr_addr == ADDR_MOVEMENT_FLAG && st_reg.flag);
    c_grab: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_stb && rd_addr == ADDR_PIXEL_DUMP_PORT && grab_valid);

endmodule

`default_nettype wire

// ===== tb/mir_spi_host.sv
// serial-port master model of the external controller
`timescale 1ns/1ps
`default_nettype none

module mir_spi_host (
    // clock
    input wire logic mclk_i,
    // serial port
    output logic ncs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        ncs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic sel();
        ncs_n_o = 1'b0;
        wait_clk(4);
    endtask

    task automatic desel();
        wait_clk(2);
        ncs_n_o = 1'b1;
        wait_clk(8);
    endtask

    // msb first, drive on fall, miso taken before next fall
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (i < 7) begin
                rx[i+1] = miso_i;
            end
            sclk_o = 1'b0;
            mosi_o = tx[i];
            wait_clk(4);
            sclk_o = 1'b1;
            wait_clk(4);
        end
        rx[0] = miso_i;
        mosi_o = ~mosi_o;
    endtask

    // address byte, data-prepare gap, data byte
    task automatic access(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] dummy;
        sel();
        xbyte(hdr, dummy);
        wait_clk(8);
        xbyte(wd, rd);
        desel();
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking testbench of the readout register block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
end

module tb_top;
    import mir_pkg::*;
    logic mclk, rst_n, ncs_n, sclk, mosi, miso, miso_oe, fdone, mvalid, pix_we, pend;
    logic [7:0] dx, dy, fmax, fmean, fmin, v;
    logic [8:0] feat, pix_addr;
    logic [6:0] pix_data;
    logic [15:0] expo;
    logic miso_line;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    // ****************************************
    // clock, design, partner
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    mir_readout_regs mir_readout_regs_i (.mclk_i(mclk), .rst_n_i(rst_n), .ncs_n_i(ncs_n),
        .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .frame_done_i(fdone), .motion_valid_i(mvalid), .motion_dx_i(dx), .motion_dy_i(dy),
        .feature_count_i(feat), .frame_max_i(fmax), .frame_mean_i(fmean), .frame_min_i(fmin),
        .pix_we_i(pix_we), .pix_addr_i(pix_addr), .pix_data_i(pix_data),
        .exposure_o(expo), .motion_pending_o(pend));

    // undriven line shows the inverse of the last bit
    assign miso_line = miso_oe ? miso : ~miso;

    mir_spi_host mir_spi_host_i (.mclk_i(mclk), .ncs_n_o(ncs_n), .sclk_o(sclk),
        .mosi_o(mosi), .miso_i(miso_line));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string nm);
        mir_spi_host_i.access({1'b0, a}, 8'h00, v);
        `CHK(nm, exp, v)
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        mir_spi_host_i.access({1'b1, a}, d, v);
    endtask

    task automatic frame(input logic [7:0] x, y, input logic [8:0] f,
                         input logic [7:0] mx, mn, lo, input logic mv);
        @(posedge mclk);
        #1;
        {fdone, mvalid, dx, dy, feat, fmax, fmean, fmin} = {1'b1, mv, x, y, f, mx, mn, lo};
        @(posedge mclk);
        #1;
        {fdone, mvalid} = 2'b00;
        @(posedge mclk);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values;
        `CHK("exposure_o", 16'h0100, expo)
        `CHK("miso_oe_o", 1'b0, miso_oe)
        rd(7'h00, PRODUCT_ID_VALUE, "product_identifier");
        rd(7'h01, REVISION_VALUE, "silicon_revision");
        rd(7'h3f, ~REVISION_VALUE, "inverted_revision");
        rd(7'h06, 8'h01, "exposure_time_high");
        rd(7'h0e, 8'h46, "active_to_idle1_delay");
        rd(7'h42, 8'h03, "burst_start_select");
        rd(7'h02, 8'h00, "movement_flag_reg");
    endtask

    task automatic t_motion;
        frame(8'h05, 8'hfd, 9'h1ff, 8'h90, 8'h80, 8'h10, 1'b1);
        `CHK("motion_pending_o", 1'b1, pend)
        rd(7'h02, 8'h80, "movement_flag_reg");
        rd(7'h03, 8'h05, "x_displacement");
        rd(7'h04, 8'hfd, "y_displacement");
        `CHK("motion_pending_o", 1'b0, pend)
        rd(7'h02, 8'h00, "movement_flag_reg");
        frame(8'h64, 8'h9c, 9'h1ff, 8'h90, 8'h80, 8'h10, 1'b1);
        frame(8'h64, 8'h9c, 9'h1ff, 8'h90, 8'h80, 8'h10, 1'b1);
        rd(7'h03, 8'h7f, "x_displacement");
        wr(7'h02, 8'hff);
        `CHK("motion_pending_o", 1'b0, pend)
        rd(7'h02, 8'h00, "movement_flag_reg");
        rd(7'h03, 8'h00, "x_displacement");
        rd(7'h04, 8'h00, "y_displacement");
    endtask

    task automatic t_stats;
        frame(8'h00, 8'h00, 9'h0fe, 8'hf8, 8'h50, 8'hc0, 1'b0);
        rd(7'h05, 8'h7f, "surface_quality");
        rd(7'h08, 8'hf8, "brightest_pixel");
        rd(7'h09, 8'h50, "mean_pixel_level");
        rd(7'h0a, 8'h7f, "darkest_pixel");
        rd(7'h06, 8'h00, "exposure_time_high");
        rd(7'h07, 8'hef, "exposure_time_low");
        `CHK("exposure_o", 16'h00ef, expo)
        wr(7'h08, 8'h00);
        rd(7'h08, 8'hf8, "brightest_pixel");
    endtask

    task automatic t_burst;
        logic [7:0] exp [7];
        exp = '{8'h01, 8'h02, 8'hff, 8'h00, 8'hef, 8'h90, 8'h80};
        frame(8'h01, 8'h02, 9'h1ff, 8'h90, 8'h80, 8'h10, 1'b1);
        mir_spi_host_i.sel();
        mir_spi_host_i.xbyte(8'h63, v);
        mir_spi_host_i.wait_clk(8);
        for (int i = 0; i < 7; i++) begin
            mir_spi_host_i.xbyte(8'h00, v);
            `CHK("movement_burst_port", exp[i], v)
        end
        mir_spi_host_i.desel();
        `CHK("motion_pending_o", 1'b0, pend)
    endtask

    task automatic t_dump;
        logic [6:0] pv [3];
        pv = '{7'h11, 7'h22, 7'h33};
        for (int i = 0; i < 3; i++) begin
            {pix_we, pix_addr, pix_data} = {1'b1, 9'(i), pv[i]};
            mir_spi_host_i.wait_clk(1);
        end
        pix_we = 1'b0;
        wr(7'h0b, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rd(7'h0b, {1'b1, pv[i]}, "pixel_dump_port");
        end
        wr(7'h0b, 8'h55);
        rd(7'h0b, {1'b1, pv[0]}, "pixel_dump_port");
    endtask

    task automatic t_config;
        wr(7'h0e, 8'h5a);
        rd(7'h0e, 8'h5a, "active_to_idle1_delay");
        rd(7'h7e, 8'h00, "unmapped");
        wr(7'h3a, 8'h5a);
        rd(7'h0e, 8'h46, "active_to_idle1_delay");
        `CHK("exposure_o", 16'h0100, expo)
    endtask

    initial begin
        {rst_n, fdone, mvalid, pix_we} = 4'b0000;
        {dx, dy, fmax, fmean, fmin, feat, pix_addr, pix_data} = '0;
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        mir_spi_host_i.wait_clk(4);
        t_reset_values();
        t_motion();
        t_stats();
        t_burst();
        t_dump();
        t_config();
        complete_run();
    end
endmodule

`default_nettype wire
